// >>> core/sccc_defines.svh
// Offsets, field positions, reset values and divide factors of the strap configuration block.
`ifndef SCCC_DEFINES_SVH
`define SCCC_DEFINES_SVH

`define SCCC_ADDR_W 4
`define SCCC_DATA_W 32
`define SCCC_CCR_OFFSET 4'h0
`define SCCC_STATUS_OFFSET 4'h4

`define SCCC_L2_CFG_LSB 0
`define SCCC_L2_CFG_MSB 2
`define SCCC_ST_STRAP_LSB 0
`define SCCC_ST_RANGE_LSB 3
`define SCCC_ST_IODIV_BIT 5
`define SCCC_ST_GFXDIV_LSB 6
`define SCCC_ST_IOFACT_LSB 9
`define SCCC_ST_PRESENT_BIT 12
`define SCCC_ST_BANKS_LSB 13
`define SCCC_ST_SIZE_LSB 16

`define SCCC_CCR_RESET 3'h0
`define SCCC_SYNC_W 6

`define SCCC_IO_DIV_HIGH 3'h4
`define SCCC_IO_DIV_LOW 3'h6
`define SCCC_GFX_DIV_00 3'h2
`define SCCC_GFX_DIV_01 3'h3
`define SCCC_GFX_DIV_10 3'h4
`define SCCC_GFX_DIV_11 3'h5

`endif

// >>> core/sccc_pkg.sv
// Types shared by the strap configuration block.
package sccc_pkg;
    typedef logic [2:0] sccc_l2_cfg_t;
    typedef logic [2:0] sccc_factor_t;
    typedef enum logic [2:0] {
        SCCC_L2_NONE,
        SCCC_L2_1X256K,
        SCCC_L2_2X256K,
        SCCC_L2_4X256K,
        SCCC_L2_1X512K,
        SCCC_L2_2X512K,
        SCCC_L2_1X1M,
        SCCC_L2_UNDEF
    } sccc_l2_layout_t;
endpackage : sccc_pkg

// >>> core/sccc_clk_div.sv
// Integer clock divider driven by an advance strobe on the reference clock.
`timescale 1ns/1ps
module sccc_clk_div
    import sccc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic advance,
    input wire sccc_factor_t divisor,
    output logic tick,
    output logic clk_out
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic wrap;

    // Odd factors give a short high phase; the duty cycle is not balanced.
    assign wrap = (count == 3'(divisor - 3'h1));
    assign tick = advance & wrap;
    assign next_count = wrap ? 3'h0 : 3'(count + 3'h1);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count <= 3'h0;
        end else if (advance) begin
            count <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_out <= 1'b0;
        end else if (advance) begin
            clk_out <= (next_count < (divisor >> 1));
        end
    end
endmodule : sccc_clk_div

// >>> core/sccc_strap_config.sv
// Strap sampling, clock dividers and cpu configuration register of the strap block.
//
// How it works
// - Graphics bus clock is I/O clock divided by 2, 3, 4 or 5 per range pins.
// - While reset is held, the three cache straps load the configuration field.
// - After reset, software writes to the configuration register replace the strapped field.
// - Strap n lands in field bit n, for n from 0 to 2.
// - Field decodes to cache absent, or bank count and total size per encoding.
// - I/O clock is the fast clock divided by 4 with strap high, else 6.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sccc_defines.svh"
module sccc_strap_config
    import sccc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] divider_range_pins,
    input wire logic io_divide_select_pin,
    input wire logic [2:0] l2_config_straps,
    input wire logic [`SCCC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`SCCC_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`SCCC_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic io_clock,
    output logic graphics_bus_clock,
    output logic l2_enable,
    output logic [2:0] l2_bank_count,
    output logic [3:0] l2_size_units
);
    logic [`SCCC_SYNC_W-1:0] sync_1;
    logic [`SCCC_SYNC_W-1:0] sync_2;
    logic [`SCCC_SYNC_W-1:0] sync_3;
    logic [`SCCC_SYNC_W-1:0] strap_level;
    logic [1:0] bus_divider_range_strap;
    logic io_divider_strap;
    logic [2:0] strap_l2_latched;
    sccc_l2_cfg_t l2_config_field;
    sccc_factor_t io_factor;
    sccc_factor_t gfx_factor;
    sccc_l2_layout_t layout;
    logic io_tick;
    logic gfx_tick;
    logic bus_req;
    logic bus_ack;
    logic ccr_hit;
    logic status_hit;
    logic [`SCCC_DATA_W-1:0] cpu_configuration_register;
    logic [`SCCC_DATA_W-1:0] status_word;

    // The pin chain carries no reset so that it keeps sampling the straps while reset is held.
    always_ff @(posedge ref_clk) begin
        sync_1 <= {io_divide_select_pin, divider_range_pins, l2_config_straps};
        sync_2 <= sync_1;
        sync_3 <= sync_2;
    end

    // A level counts only once the second and third stage agree.
    always_ff @(posedge ref_clk) begin
        if (sync_2 == sync_3) begin
            strap_level <= sync_3;
        end
    end

    // Clock straps are frozen at reset so the dividers never change ratio in operation.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            io_divider_strap <= strap_level[5];
            bus_divider_range_strap <= strap_level[4:3];
            strap_l2_latched <= strap_level[2:0];
        end
    end

    always_comb begin
        io_factor = io_divider_strap ? `SCCC_IO_DIV_HIGH : `SCCC_IO_DIV_LOW;
    end

    always_comb begin
        case (bus_divider_range_strap)
            2'h0: gfx_factor = `SCCC_GFX_DIV_00;
            2'h1: gfx_factor = `SCCC_GFX_DIV_01;
            2'h2: gfx_factor = `SCCC_GFX_DIV_10;
            2'h3: gfx_factor = `SCCC_GFX_DIV_11;
            default: gfx_factor = `SCCC_GFX_DIV_00;
        endcase
    end

    // The reference clock stands in for the fast clock; both outputs are registered waveforms.
    sccc_clk_div io_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .advance(1'b1),
        .divisor(io_factor),
        .tick(io_tick),
        .clk_out(io_clock)
    );

    sccc_clk_div gfx_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .advance(io_tick),
        .divisor(gfx_factor),
        .tick(gfx_tick),
        .clk_out(graphics_bus_clock)
    );

    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign ccr_hit = (avs_address[3:2] == 2'(`SCCC_CCR_OFFSET >> 2));
    assign status_hit = (avs_address[3:2] == 2'(`SCCC_STATUS_OFFSET >> 2));

    // Every access is answered one cycle after it is raised.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // A write lands only on the edge that ends its wait, never while the master still waits.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            l2_config_field <= strap_level[2:0];
        end else if (avs_write && bus_ack && ccr_hit && avs_byteenable[0]) begin
            l2_config_field <= avs_writedata[`SCCC_L2_CFG_MSB:`SCCC_L2_CFG_LSB];
        end
    end

    always_comb begin
        cpu_configuration_register = 32'h0000_0000;
        cpu_configuration_register[`SCCC_L2_CFG_MSB:`SCCC_L2_CFG_LSB] = l2_config_field;
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SCCC_ST_STRAP_LSB +: 3] = strap_l2_latched;
        status_word[`SCCC_ST_RANGE_LSB +: 2] = bus_divider_range_strap;
        status_word[`SCCC_ST_IODIV_BIT] = io_divider_strap;
        status_word[`SCCC_ST_GFXDIV_LSB +: 3] = gfx_factor;
        status_word[`SCCC_ST_IOFACT_LSB +: 3] = io_factor;
        status_word[`SCCC_ST_PRESENT_BIT] = l2_enable;
        status_word[`SCCC_ST_BANKS_LSB +: 3] = l2_bank_count;
        status_word[`SCCC_ST_SIZE_LSB +: 4] = l2_size_units;
    end

    // Unmapped addresses read as zero and ignore writes.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            if (ccr_hit) begin
                avs_readdata <= cpu_configuration_register;
            end else if (status_hit) begin
                avs_readdata <= status_word;
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    always_comb begin
        case (l2_config_field)
            3'h0: layout = SCCC_L2_NONE;
            3'h1: layout = SCCC_L2_1X256K;
            3'h2: layout = SCCC_L2_2X256K;
            3'h3: layout = SCCC_L2_4X256K;
            3'h4: layout = SCCC_L2_1X512K;
            3'h5: layout = SCCC_L2_2X512K;
            3'h6: layout = SCCC_L2_1X1M;
            default: layout = SCCC_L2_UNDEF;
        endcase
    end

    // Sizes are in units of 256 KB; the undefined code disables the cache entirely.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            l2_enable <= 1'b0;
            l2_bank_count <= 3'h0;
            l2_size_units <= 4'h0;
        end else begin
            case (layout)
                SCCC_L2_1X256K: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h1;
                    l2_size_units <= 4'h1;
                end
                SCCC_L2_2X256K: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h2;
                    l2_size_units <= 4'h2;
                end
                SCCC_L2_4X256K: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h4;
                    l2_size_units <= 4'h4;
                end
                SCCC_L2_1X512K: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h1;
                    l2_size_units <= 4'h2;
                end
                SCCC_L2_2X512K: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h2;
                    l2_size_units <= 4'h4;
                end
                SCCC_L2_1X1M: begin
                    l2_enable <= 1'b1;
                    l2_bank_count <= 3'h1;
                    l2_size_units <= 4'h4;
                end
                default: begin
                    l2_enable <= 1'b0;
                    l2_bank_count <= 3'h0;
                    l2_size_units <= 4'h0;
                end
            endcase
        end
    end

    // Helper counters measure divider periods for the checks below.
    logic [3:0] io_gap;
    logic io_seen;
    logic [3:0] gfx_gap;
    logic gfx_seen;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            io_gap <= 4'h0;
            io_seen <= 1'b0;
        end else begin
            io_gap <= io_tick ? 4'h1 : 4'(io_gap + 4'h1);
            io_seen <= io_seen | io_tick;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gfx_gap <= 4'h0;
            gfx_seen <= 1'b0;
        end else if (io_tick) begin
            gfx_gap <= gfx_tick ? 4'h1 : 4'(gfx_gap + 4'h1);
            gfx_seen <= gfx_seen | gfx_tick;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    io_period_check_a: assert property (
        (io_tick && io_seen) |-> (io_gap == {1'b0, io_factor})
    ) else $error("io clock period differs from strap factor");

    io_strap_ratio_a: assert property (
        io_tick |-> ##1 (!io_tick) [*3] ##1 (io_divider_strap ? io_tick : !io_tick)
    ) else $error("io tick spacing wrong for divider strap");

    gfx_period_check_a: assert property (
        (gfx_tick && gfx_seen) |-> (gfx_gap == {1'b0, gfx_factor})
    ) else $error("graphics clock period differs from range factor");

    strap_capture_a: assert property (
        $rose(rst_n) |-> (l2_config_field == $past(strap_level[2:0]))
    ) else $error("cache field not loaded from straps at reset");

    ccr_write_update_a: assert property (
        (avs_write && !avs_waitrequest && ccr_hit && avs_byteenable[0])
        |=> (cpu_configuration_register[2:0] == $past(avs_writedata[2:0]))
    ) else $error("configuration write not applied");

    l2_decode_size_a: assert property (
        (l2_config_field == 3'h5) |=> (l2_enable && l2_bank_count == 3'h2 && l2_size_units == 4'h4)
    ) else $error("cache layout decode wrong");

    l2_undef_off_a: assert property (
        (l2_config_field == 3'h7) |=> (!l2_enable && l2_size_units == 4'h0)
    ) else $error("undefined cache code left cache enabled");

    bus_answer_bound_a: assert property (
        $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest
    ) else $error("bus answer not in one cycle");

    ccr_read_back_a: assert property (
        (avs_read && !avs_waitrequest && ccr_hit)
        |-> (avs_readdata[2:0] == l2_config_field && avs_readdata[31:3] == 29'h0)
    ) else $error("configuration read data wrong");

    ccr_write_hold_a: assert property (
        (avs_write && avs_waitrequest) |=> $stable(l2_config_field)
    ) else $error("configuration field changed before the write was answered");

    status_factor_read_a: assert property (
        (avs_read && !avs_waitrequest && status_hit)
        |-> (avs_readdata[11:6] == {io_factor, gfx_factor})
    ) else $error("status read shows wrong divide factors");

    strap_freeze_a: assert property (
        rst_n |=> $stable({io_divider_strap, bus_divider_range_strap, strap_l2_latched})
    ) else $error("latched straps moved outside reset");
endmodule : sccc_strap_config

// >>> test/sccc_strap_board.sv
// Board strap resistors that set the configuration pin levels of the strap block.
`timescale 1ns/1ps
module sccc_strap_board (
    input wire logic [1:0] range_load,
    input wire logic io_load,
    input wire logic [2:0] cache_load,
    output logic [1:0] divider_range_pins,
    output logic io_divide_select_pin,
    output logic [2:0] l2_config_straps
);
    // Every pin sits on a pull-up or a pull-down, so none of them ever floats.
    // The loaded range keeps the graphics bus clock inside its allowed window.
    assign divider_range_pins = range_load;
    assign io_divide_select_pin = io_load;
    assign l2_config_straps = cache_load;
endmodule : sccc_strap_board

// >>> test/tb_top.sv
// Self-checking testbench of the strap configuration block.
`timescale 1ns/1ps
`include "sccc_defines.svh"
module tb_top;
    logic ref_clk;
    logic rst_n;
    logic [1:0] range_load;
    logic io_load;
    logic [2:0] cache_load;
    logic [1:0] divider_range_pins;
    logic io_divide_select_pin;
    logic [2:0] l2_config_straps;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic io_clock;
    logic graphics_bus_clock;
    logic l2_enable;
    logic [2:0] l2_bank_count;
    logic [3:0] l2_size_units;
    logic [31:0] rd;
    logic [2:0] iof;
    logic [2:0] gf;
    int err_total;
    int tests_run;
    int cyc;
    int i;
    localparam logic [2:0] BANKS [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h1, 3'h0};
    localparam logic [3:0] UNITS [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h2, 4'h4, 4'h4, 4'h0};

    sccc_strap_board u_board (
        .range_load(range_load),
        .io_load(io_load),
        .cache_load(cache_load),
        .divider_range_pins(divider_range_pins),
        .io_divide_select_pin(io_divide_select_pin),
        .l2_config_straps(l2_config_straps)
    );

    sccc_strap_config u_dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .divider_range_pins(divider_range_pins),
        .io_divide_select_pin(io_divide_select_pin),
        .l2_config_straps(l2_config_straps),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .io_clock(io_clock),
        .graphics_bus_clock(graphics_bus_clock),
        .l2_enable(l2_enable),
        .l2_bank_count(l2_bank_count),
        .l2_size_units(l2_size_units)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: value %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic timeout();
        err_total++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask : timeout

    // The request stays up until waitrequest is seen low; a wait past 20 edges ends the test as a timeout.
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                       input logic [3:0] be, output logic [31:0] rdata);
        logic busy;
        int n;
        busy = 1'b1;
        n = 0;
        @(posedge ref_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_byteenable <= be;
        // Outputs are read as they stand at the edge, before the slave's flops move.
        while (busy !== 1'b0) begin
            @(posedge ref_clk);
            n++;
            if (avs_waitrequest === 1'b0) begin
                busy = 1'b0;
                rdata = avs_readdata;
            end else if (n > 20) begin
                timeout();
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic do_reset(input logic [2:0] cache, input logic [1:0] rng, input logic io);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cache_load <= cache;
        range_load <= rng;
        io_load <= io;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset

    // Counts reference cycles between two rising edges of one of the divided clocks.
    task automatic period(input logic which, output int cnt);
        logic prev;
        logic now;
        int n;
        int rises;
        prev = 1'b1;
        rises = 0;
        cnt = 0;
        for (n = 0; n < 200 && rises < 2; n++) begin
            @(posedge ref_clk);
            #1;
            now = which ? graphics_bus_clock : io_clock;
            if (rises == 1) cnt++;
            if (now === 1'b1 && prev === 1'b0) rises++;
            prev = now;
        end
        if (rises < 2) timeout();
    endtask : period

    initial begin
        err_total = 0;
        tests_run = 0;
        rst_n = 1'b0;
        range_load = 2'h0;
        io_load = 1'b0;
        cache_load = 3'h0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        // Each pass straps a new cache code, the range from its low bits and the io divider from its top bit, then reads back.
        for (i = 0; i < 8; i++) begin
            do_reset(i[2:0], i[1:0], i[2]);
            iof = i[2] ? 3'h4 : 3'h6;
            gf = {1'b0, i[1:0]} + 3'h2;
            bus(1'b0, `SCCC_CCR_OFFSET, 32'h0000_0000, 4'hF, rd);
            check(rd, {29'h0, i[2:0]});
            check({l2_enable, l2_bank_count, l2_size_units},
                  {(i != 0 && i != 7), BANKS[i], UNITS[i]});
            if (i == 7) check(l2_enable, 1'b0);
            bus(1'b0, `SCCC_STATUS_OFFSET, 32'h0000_0000, 4'hF, rd);
            check(rd[11:6], {iof, gf});
            period(1'b0, cyc);
            check(cyc, iof);
            period(1'b1, cyc);
            check(cyc, iof * gf);
        end
        // Straps moved after reset must not reach the field.
        @(posedge ref_clk);
        cache_load <= 3'h3;
        repeat (10) @(posedge ref_clk);
        bus(1'b0, `SCCC_CCR_OFFSET, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0007);
        bus(1'b1, `SCCC_CCR_OFFSET, 32'hFFFF_FFF5, 4'hF, rd);
        bus(1'b0, `SCCC_CCR_OFFSET, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0005);
        repeat (3) @(posedge ref_clk);
        check({l2_enable, l2_bank_count, l2_size_units}, {1'b1, 3'h2, 4'h4});
        // Writes without the low byte lane, to status or to a hole, change nothing.
        bus(1'b1, `SCCC_CCR_OFFSET, 32'h0000_0002, 4'hE, rd);
        bus(1'b1, `SCCC_STATUS_OFFSET, 32'h0000_0002, 4'hF, rd);
        bus(1'b1, 4'h8, 32'h0000_0002, 4'hF, rd);
        bus(1'b0, `SCCC_CCR_OFFSET, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0005);
        bus(1'b0, 4'h8, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        bus(1'b1, `SCCC_CCR_OFFSET, 32'h0000_0007, 4'h1, rd);
        repeat (3) @(posedge ref_clk);
        check({l2_enable, l2_bank_count, l2_size_units}, 8'h00);
        print_verdict();
    end
endmodule : tb_top
